/* shared/host_ctl_defines.svh */
`ifndef HOST_CTL_DEFINES_SVH
`define HOST_CTL_DEFINES_SVH

// ==========================================================================
// Clock and parallel-port timing.
// ==========================================================================
`define CLK_PERIOD_NS    40
`define ACCESS_NS        120
`define ACCESS_CYC       ((`ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SYNC_CYC         2
`define STROBE_CYC       (`ACCESS_CYC + `SYNC_CYC)
`define RECOVER_NS       200
`define RECOVER_CYC      ((`RECOVER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RST_PULSE_NS     1000
`define RST_PULSE_CYC    ((`RST_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ==========================================================================
// Device register addresses on its parallel port.
// ==========================================================================
`define DEV_READY_ADDR   8'h00
`define DEV_GRESET_ADDR  8'h01
`define DEV_CHSTAT_BASE  8'h10
`define DEV_CHRESET_BASE 8'h20
`define RESET_KEY_FIRST  8'hA5
`define RESET_KEY_SECOND 8'h5A
`define READY_ARM_VALUE  8'h00
`define READY_DONE_BIT   0
`define ILLEGAL_BIT      2

// ==========================================================================
// Wishbone register map of this controller (byte addresses).
// ==========================================================================
`define WB_CMD_ADDR      4'h0
`define WB_STATUS_ADDR   4'h4
`define WB_RDATA_ADDR    4'h8
`define CMD_OP_LSB       0
`define CMD_CHAN_LSB     4
`define CMD_DATA_LSB     8
`define CMD_ADDR_LSB     16
`define ST_BUSY_BIT      0
`define ST_READY_BIT     1
`define ST_IRQ_BIT       2
`define ST_ILLEGAL_BIT   3

`endif

/* shared/host_ctl_pkg.sv */
package host_ctl_pkg;

    // Commands that software places in the command register.
    typedef enum logic [2:0] {
        OP_NONE    = 3'h0,
        OP_WRITE   = 3'h1,
        OP_READ    = 3'h2,
        OP_GRESET  = 3'h3,
        OP_CRESET  = 3'h4,
        OP_HWRESET = 3'h5,
        OP_CHSTAT  = 3'h6,
        OP_POLL    = 3'h7
    } op_t;

    // Engine states, one-hot.
    typedef enum logic [4:0] {
        ST_IDLE    = 5'h01,
        ST_SETUP   = 5'h02,
        ST_STROBE  = 5'h04,
        ST_RECOVER = 5'h08,
        ST_PULSE   = 5'h10
    } state_t;

endpackage : host_ctl_pkg

/* hdl/pin_sync.sv */
`timescale 1ns/1ps

// ==========================================================================
// Two-stage synchroniser for pins arriving from the device.
// ==========================================================================
module pin_sync #(
    parameter int          WIDTH   = 9,
    parameter logic [8:0]  RST_VAL = 9'h100
) (
    // Clock and reset.
    input  wire logic              clock,
    input  wire logic              rstn,
    // Pin side and clock-domain side.
    input  wire logic [WIDTH-1:0]  pins,
    output logic      [WIDTH-1:0]  synced
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    // The first stage feeds only the second one.
    always_comb
    begin
        meta_d = pins;
        sync_d = meta_q;
    end

    // Both stages reset to the idle level of the pins.
    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            meta_q <= RST_VAL[WIDTH-1:0];
            sync_q <= RST_VAL[WIDTH-1:0];
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign synced = sync_q;

endmodule : pin_sync

/* hdl/host_ctl.sv */
// Notes on behaviour
// - Writes ignored during init; host polls ready.
// - Global reset: write A5h then 5Ah.
// - Channel reset: A5h then 5Ah to channel.
// - Data changes only while clock low.
// - Transfers begin only on idle bus.
// - Start falls, stop rises, clock high.
// - Eight bits then one acknowledge clock.
// - Acknowledger holds data low through clock high.
// - Master withholds last ack; slave releases data.
// - Fast-channel slaves never acknowledge.
`timescale 1ns/1ps

`include "host_ctl_defines.svh"

module host_ctl (
    // Clock and reset.
    input  wire logic        clock,
    input  wire logic        rstn,
    // Wishbone slave.
    input  wire logic        cyc,
    input  wire logic        stb,
    input  wire logic        we,
    input  wire logic [3:0]  adr,
    input  wire logic [3:0]  sel,
    input  wire logic [31:0] dat_w,
    output logic      [31:0] dat_r,
    output logic             ack,
    // Device parallel port.
    output logic      [7:0]  dev_addr,
    input  wire logic [7:0]  dev_data_in,
    output logic      [7:0]  dev_data_out,
    output logic             dev_data_oe,
    output logic             dev_cs_n,
    output logic             dev_wr_n,
    output logic             dev_rd_n,
    output logic             dev_reset_n,
    input  wire logic        dev_int_n
);
    import host_ctl_pkg::*;

    // ======================================================================
    // Helpers.
    // ======================================================================
    // Key byte of a two-write reset sequence.
    function automatic logic [7:0] reset_key(input logic second);
        reset_key = second ? `RESET_KEY_SECOND : `RESET_KEY_FIRST;
    endfunction : reset_key

    // Access for the current step: {is_read, address, data}.
    function automatic logic [16:0] access_of(input op_t op, input logic step, input logic poll,
                                              input logic arm, input logic [1:0] chan,
                                              input logic [7:0] a, input logic [7:0] d);
        logic [7:0] ch;
        ch = {6'h00, chan};
        if (poll)
            access_of = arm ? {1'b0, `DEV_READY_ADDR, `READY_ARM_VALUE} : {1'b1, `DEV_READY_ADDR, 8'h00};
        else
        begin
            unique case (op)
                OP_WRITE:  access_of = {1'b0, a, d};
                OP_READ:   access_of = {1'b1, a, 8'h00};
                OP_CHSTAT: access_of = {1'b1, 8'(`DEV_CHSTAT_BASE + ch), 8'h00};
                OP_GRESET: access_of = {1'b0, `DEV_GRESET_ADDR, reset_key(step)};
                OP_CRESET: access_of = {1'b0, 8'(`DEV_CHRESET_BASE + ch), reset_key(step)};
                default:   access_of = {1'b1, `DEV_READY_ADDR, 8'h00};
            endcase
        end
    endfunction : access_of

    // ======================================================================
    // Pin synchronisation.
    // ======================================================================
    logic [8:0] pins_sync;

    pin_sync #(
        .WIDTH   (9),
        .RST_VAL (9'h100)
    ) u_sync (
        .clock  (clock),
        .rstn   (rstn),
        .pins   ({dev_int_n, dev_data_in}),
        .synced (pins_sync)
    );

    logic [7:0] data_sync;
    logic       int_sync_n;
    assign data_sync  = pins_sync[7:0];
    assign int_sync_n = pins_sync[8];

    // ======================================================================
    // Bus decode.
    // ======================================================================
    logic   req;
    logic   start;
    logic   illegal_clr;
    logic   ack_q;
    logic   ack_d;
    logic   [31:0] dat_r_q;
    logic   [31:0] dat_r_d;
    state_t state_q;
    state_t state_d;

    // A request is acted on in its first cycle only; ack follows one edge later.
    assign req         = cyc && stb && !ack_q;
    assign start       = req && we && (adr == `WB_CMD_ADDR) && (sel == 4'hF) && (state_q == ST_IDLE);
    assign illegal_clr = req && we && (adr == `WB_STATUS_ADDR) && sel[0] && dat_w[`ST_ILLEGAL_BIT];

    // ======================================================================
    // Access engine.
    // ======================================================================
    op_t        op_q, op_d;
    logic [1:0] chan_q, chan_d;
    logic [7:0] a_q, a_d, d_q, d_d;
    logic       step_q, step_d, poll_q, poll_d, arm_q, arm_d;
    logic       ready_q, ready_d, illegal_q, illegal_d;
    logic [5:0] cnt_q, cnt_d;
    logic [7:0] rdata_q, rdata_d;
    logic [7:0] addr_q, addr_d, dout_q, dout_d;
    logic       oe_q, oe_d, cs_n_q, cs_n_d, wr_n_q, wr_n_d, rd_n_q, rd_n_d, rst_n_q, rst_n_d;
    logic [16:0] acc;
    op_t        new_op;

    assign acc    = access_of(op_q, step_q, poll_q, arm_q, chan_q, a_q, d_q);
    assign new_op = op_t'(dat_w[`CMD_OP_LSB +: 3]);

    // Next state of the engine and of every device pin.
    always_comb
    begin
        state_d = state_q;  op_d = op_q;  chan_d = chan_q;  a_d = a_q;  d_d = d_q;
        step_d = step_q;  poll_d = poll_q;  arm_d = arm_q;  ready_d = ready_q;
        illegal_d = illegal_q;  cnt_d = cnt_q;  rdata_d = rdata_q;
        addr_d = addr_q;  dout_d = dout_q;  oe_d = oe_q;  cs_n_d = cs_n_q;
        wr_n_d = wr_n_q;  rd_n_d = rd_n_q;  rst_n_d = rst_n_q;
        if (illegal_clr)
            illegal_d = 1'b0;
        unique case (state_q)
            ST_IDLE:
            begin
                if (start)
                begin
                    op_d   = new_op;
                    chan_d = dat_w[`CMD_CHAN_LSB +: 2];
                    d_d    = dat_w[`CMD_DATA_LSB +: 8];
                    a_d    = dat_w[`CMD_ADDR_LSB +: 8];
                    step_d = 1'b0;
                    arm_d  = 1'b0;
                    poll_d = 1'b0;
                    if (new_op == OP_HWRESET)
                    begin
                        rst_n_d = 1'b0;
                        ready_d = 1'b0;
                        cnt_d   = 6'(`RST_PULSE_CYC);
                        state_d = ST_PULSE;
                    end
                    else if (new_op == OP_POLL)
                    begin
                        poll_d  = 1'b1;
                        ready_d = 1'b0;
                        state_d = ST_SETUP;
                    end
                    // Writes are refused until the device has been seen ready.
                    else if (new_op != OP_NONE && (ready_q || new_op == OP_READ || new_op == OP_CHSTAT))
                        state_d = ST_SETUP;
                end
            end
            ST_SETUP:
            begin
                cs_n_d  = 1'b0;
                addr_d  = acc[15:8];
                dout_d  = acc[7:0];
                oe_d    = !acc[16];
                cnt_d   = 6'(`STROBE_CYC);
                state_d = ST_STROBE;
            end
            ST_STROBE:
            begin
                rd_n_d = !acc[16];
                wr_n_d = acc[16];
                cnt_d  = cnt_q - 6'h01;
                if (cnt_q == 6'h00)
                begin
                    rd_n_d  = 1'b1;
                    wr_n_d  = 1'b1;
                    cnt_d   = 6'(`RECOVER_CYC);
                    state_d = ST_RECOVER;
                    if (acc[16])
                        rdata_d = data_sync;
                    // A set in the same cycle as a clear wins.
                    if (acc[16] && !poll_q && op_q == OP_CHSTAT && data_sync[`ILLEGAL_BIT])
                        illegal_d = 1'b1;
                end
            end
            ST_RECOVER:
            begin
                cs_n_d = 1'b1;
                oe_d   = 1'b0;
                cnt_d  = cnt_q - 6'h01;
                if (cnt_q == 6'h00)
                begin
                    state_d = ST_SETUP;
                    if (poll_q)
                    begin
                        if (arm_q)
                        begin
                            ready_d = 1'b1;
                            arm_d   = 1'b0;
                            poll_d  = 1'b0;
                            state_d = ST_IDLE;
                        end
                        // Ready seen: write zero to arm the line checks.
                        else if (rdata_q[`READY_DONE_BIT])
                            arm_d = 1'b1;
                    end
                    // The second key follows the first with no other write between.
                    else if (!step_q && (op_q == OP_GRESET || op_q == OP_CRESET))
                        step_d = 1'b1;
                    else if (op_q == OP_GRESET)
                    begin
                        poll_d  = 1'b1;
                        ready_d = 1'b0;
                    end
                    else
                        state_d = ST_IDLE;
                end
            end
            ST_PULSE:
            begin
                cnt_d = cnt_q - 6'h01;
                if (cnt_q == 6'h01)
                begin
                    rst_n_d = 1'b1;
                    poll_d  = 1'b1;
                    state_d = ST_SETUP;
                end
            end
        endcase
    end

    // Engine registers; strobe and reset pins idle high, address and data out low, the data bus released.
    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            state_q <= ST_IDLE;  op_q <= OP_NONE;  chan_q <= 2'h0;  a_q <= 8'h00;  d_q <= 8'h00;
            step_q <= 1'b0;  poll_q <= 1'b0;  arm_q <= 1'b0;  ready_q <= 1'b0;  illegal_q <= 1'b0;
            cnt_q <= 6'h00;  rdata_q <= 8'h00;  addr_q <= 8'h00;  dout_q <= 8'h00;  oe_q <= 1'b0;
            cs_n_q <= 1'b1;  wr_n_q <= 1'b1;  rd_n_q <= 1'b1;  rst_n_q <= 1'b1;
        end
        else
        begin
            state_q <= state_d;  op_q <= op_d;  chan_q <= chan_d;  a_q <= a_d;  d_q <= d_d;
            step_q <= step_d;  poll_q <= poll_d;  arm_q <= arm_d;  ready_q <= ready_d;
            illegal_q <= illegal_d;  cnt_q <= cnt_d;  rdata_q <= rdata_d;  addr_q <= addr_d;
            dout_q <= dout_d;  oe_q <= oe_d;  cs_n_q <= cs_n_d;  wr_n_q <= wr_n_d;
            rd_n_q <= rd_n_d;  rst_n_q <= rst_n_d;
        end
    end

    assign dev_addr     = addr_q;
    assign dev_data_out = dout_q;
    assign dev_data_oe  = oe_q;
    assign dev_cs_n     = cs_n_q;
    assign dev_wr_n     = wr_n_q;
    assign dev_rd_n     = rd_n_q;
    assign dev_reset_n  = rst_n_q;

    // ======================================================================
    // Wishbone answer.
    // ======================================================================
    // Read mux; unmapped addresses answer with zero rather than an error.
    always_comb
    begin
        ack_d   = req;
        dat_r_d = 32'h0000_0000;
        if (req && !we)
        begin
            unique case (adr)
                `WB_CMD_ADDR:    dat_r_d = {8'h00, a_q, d_q, 2'h0, chan_q, 1'b0, op_q};
                `WB_STATUS_ADDR: dat_r_d = {28'h0000000, illegal_q, !int_sync_n, ready_q, state_q != ST_IDLE};
                `WB_RDATA_ADDR:  dat_r_d = {24'h000000, rdata_q};
                default:         dat_r_d = 32'h0000_0000;
            endcase
        end
    end

    // Bus answer registers.
    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            ack_q   <= 1'b0;
            dat_r_q <= 32'h0000_0000;
        end
        else
        begin
            ack_q   <= ack_d;
            dat_r_q <= dat_r_d;
        end
    end

    assign ack   = ack_q;
    assign dat_r = dat_r_q;

    // ======================================================================
    // Assertions.
    // ======================================================================
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    // Length of the reset pulse, counted for the check below.
    logic [5:0] pulse_len_q;
    always_ff @(posedge clock)
    begin
        if (!rstn)
            pulse_len_q <= 6'h00;
        else if (!rst_n_q)
            pulse_len_q <= pulse_len_q + 6'h01;
        else
            pulse_len_q <= 6'h00;
    end

    ack_single_a:
        assert property (ack_q |=> !ack_q) else $error("ack held for two cycles");
    ack_prompt_a:
        assert property (cyc && stb && !ack_q |=> ack_q) else $error("request not answered next cycle");
    key_order_a:
        assert property ($rose(wr_n_q) && addr_q == `DEV_GRESET_ADDR && dout_q == `RESET_KEY_FIRST
                         |-> ##[1:12] (!wr_n_q && addr_q == `DEV_GRESET_ADDR && dout_q == `RESET_KEY_SECOND))
        else $error("second global key missing");
    chan_key_order_a:
        assert property ($rose(wr_n_q) && op_q == OP_CRESET && dout_q == `RESET_KEY_FIRST
                         |-> ##[1:12] (!wr_n_q && dout_q == `RESET_KEY_SECOND))
        else $error("second channel key missing");
    no_early_write_a:
        assert property (!wr_n_q |-> ready_q || arm_q || op_q == OP_GRESET) else $error("write while not ready");
    arm_zero_a:
        assert property (!wr_n_q && addr_q == `DEV_READY_ADDR |-> dout_q == `READY_ARM_VALUE)
        else $error("ready register armed with nonzero");
    pulse_len_a:
        assert property ($rose(rst_n_q) |-> pulse_len_q == 6'(`RST_PULSE_CYC))
        else $error("reset pulse length wrong");
    strobe_safe_a:
        assert property ((!rd_n_q || !wr_n_q) |-> !cs_n_q && !(!rd_n_q && !wr_n_q) && !(!rd_n_q && oe_q))
        else $error("strobe conflict");
    illegal_seen_a:
        assert property (state_q == ST_STROBE && cnt_q == 6'h00 && op_q == OP_CHSTAT && !poll_q
                         && data_sync[`ILLEGAL_BIT] |=> illegal_q)
        else $error("illegal flag not captured");

    global_reset_c: cover property ($rose(ready_q) && op_q == OP_GRESET);
    chan_reset_c:   cover property ($rose(wr_n_q) && dout_q == `RESET_KEY_SECOND && op_q == OP_CRESET);
    illegal_c:      cover property ($rose(illegal_q));
    hw_reset_c:     cover property ($rose(ready_q) && op_q == OP_HWRESET);

endmodule : host_ctl

/* test/dev_model.sv */
`timescale 1ns/1ps

// ==========================================================================
// Behavioural model of the device seen through its parallel port.
// ==========================================================================
module dev_model #(
    parameter int INIT_CYC = 40
) (
    // Clock.
    input  wire logic       clock,
    // Parallel port: pins driven by the host, read data and interrupt back to it.
    input  wire logic [7:0] dev_addr,
    input  wire logic [7:0] dev_data_out,
    input  wire logic       dev_data_oe,
    input  wire logic       dev_cs_n,
    input  wire logic       dev_wr_n,
    input  wire logic       dev_rd_n,
    input  wire logic       dev_reset_n,
    output logic      [7:0] dev_data_in,
    output logic            dev_int_n,
    // Fault injection from the bench.
    input  wire logic       inj_valid,
    input  wire logic [1:0] inj_chan
);
    logic [7:0] mem [16];
    logic [3:0] illegal_q;
    logic [7:0] last_q;
    logic [7:0] key_addr_q;
    logic [7:0] rd_val;
    logic       key_q;
    logic       wr_n_q;
    logic       armed_q;
    int         init_cnt_q;
    int         init_runs;
    int         low_cyc;
    int         low_len;

    // Power-up state; the init phase starts at once.
    initial
    begin
        init_cnt_q = INIT_CYC;
        {illegal_q, last_q, key_addr_q, key_q, armed_q} = '0;
        {init_runs, low_cyc, low_len} = '0;
        wr_n_q = 1'b1;
        foreach (mem[i]) mem[i] = 8'h00;
    end

    // Read mux: ready at 0x, channel status at 1x, scratch bytes at 4x.
    always_comb
    begin
        case (dev_addr[7:4])
            4'h0:    rd_val = {7'h00, init_cnt_q == 0};
            4'h1:    rd_val = {5'h00, illegal_q[dev_addr[1:0]], 2'h0};
            4'h4:    rd_val = mem[dev_addr[3:0]];
            default: rd_val = 8'h00;
        endcase
    end

    // A released bus shows the inverse of the last byte, so stale data never passes for fresh.
    assign dev_data_in = (!dev_cs_n && !dev_rd_n) ? rd_val : ~last_q;
    assign dev_int_n   = ~|illegal_q;

    // Reset handling, init countdown, writes taken on the rising write strobe.
    always @(posedge clock)
    begin
        wr_n_q <= dev_wr_n;
        if (!dev_cs_n && !dev_rd_n)
            last_q <= rd_val;
        if (!dev_reset_n)
        begin
            low_cyc    <= low_cyc + 1;
            init_cnt_q <= INIT_CYC;
            illegal_q  <= 4'h0;
            armed_q    <= 1'b0;
            key_q      <= 1'b0;
            foreach (mem[i]) mem[i] <= 8'h00;
        end
        else
        begin
            if (low_cyc != 0)
            begin
                low_len   <= low_cyc;
                low_cyc   <= 0;
                init_runs <= init_runs + 1;
            end
            if (init_cnt_q != 0)
                init_cnt_q <= init_cnt_q - 1;
            if (inj_valid && armed_q)
                illegal_q[inj_chan] <= 1'b1;
            if (!dev_cs_n && !wr_n_q && dev_wr_n && dev_data_oe && init_cnt_q == 0)
            begin
                key_q <= 1'b0;
                if (key_q && dev_data_out == 8'h5A && dev_addr == key_addr_q)
                begin
                    if (dev_addr == 8'h01)
                    begin
                        init_cnt_q <= INIT_CYC;
                        init_runs  <= init_runs + 1;
                        illegal_q  <= 4'h0;
                        armed_q    <= 1'b0;
                        foreach (mem[i]) mem[i] <= 8'h00;
                    end
                    else
                        illegal_q[dev_addr[1:0]] <= 1'b0;
                end
                else if (dev_data_out == 8'hA5 && (dev_addr == 8'h01 || dev_addr[7:4] == 4'h2))
                begin
                    key_q      <= 1'b1;
                    key_addr_q <= dev_addr;
                end
                else if (dev_addr == 8'h00 && dev_data_out == 8'h00)
                    armed_q <= 1'b1;
                else if (dev_addr[7:4] == 4'h4)
                    mem[dev_addr[3:0]] <= dev_data_out;
            end
        end
    end
endmodule : dev_model

/* test/testbench.sv */
`timescale 1ns/1ps

`include "host_ctl_defines.svh"

module testbench;
    import host_ctl_pkg::*;

    logic        clock, rstn, cyc, stb, we, ack, inj_valid;
    logic [3:0]  adr, sel;
    logic [31:0] dat_w, dat_r, q;
    logic [1:0]  inj_chan, ch;
    logic [7:0]  dev_addr, dev_data_in, dev_data_out, a, d;
    logic        dev_data_oe, dev_cs_n, dev_wr_n, dev_rd_n, dev_reset_n, dev_int_n;
    int          n_errors, total_checks, runs0;

    host_ctl u_dut (.clock(clock), .rstn(rstn), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
        .dat_w(dat_w), .dat_r(dat_r), .ack(ack), .dev_addr(dev_addr), .dev_data_in(dev_data_in),
        .dev_data_out(dev_data_out), .dev_data_oe(dev_data_oe), .dev_cs_n(dev_cs_n), .dev_wr_n(dev_wr_n),
        .dev_rd_n(dev_rd_n), .dev_reset_n(dev_reset_n), .dev_int_n(dev_int_n));

    dev_model u_model (.clock(clock), .dev_addr(dev_addr), .dev_data_out(dev_data_out),
        .dev_data_oe(dev_data_oe), .dev_cs_n(dev_cs_n), .dev_wr_n(dev_wr_n), .dev_rd_n(dev_rd_n),
        .dev_reset_n(dev_reset_n), .dev_data_in(dev_data_in), .dev_int_n(dev_int_n),
        .inj_valid(inj_valid), .inj_chan(inj_chan));

    // 25 MHz clock.
    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // ==========================================================================
    // Shared tasks.
    // ==========================================================================
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check

    task automatic conclude();
        $display("checks %0d, mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude

    // One classic cycle; the request stands until ack is sampled high, then one idle cycle.
    task automatic wb_cycle(input logic w, input logic [3:0] ad, input logic [31:0] wd, input logic [3:0] s,
                            output logic [31:0] rd);
        int n;
        n = 0;
        cyc   <= 1'b1;
        stb   <= 1'b1;
        we    <= w;
        adr   <= ad;
        dat_w <= wd;
        sel   <= s;
        do
        begin
            @(posedge clock);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rd = dat_r;
        if (n >= 20)
        begin
            n_errors++;
            conclude();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        @(posedge clock);
    endtask : wb_cycle

    // Issues a command and polls the busy bit under a bound.
    task automatic run_cmd(input op_t op, input logic [1:0] c, input logic [7:0] dd, input logic [7:0] aa);
        int n;
        n = 0;
        wb_cycle(1'b1, `WB_CMD_ADDR, {8'h00, aa, dd, 2'b00, c, 1'b0, op}, 4'hF, q);
        do
        begin
            wb_cycle(1'b0, `WB_STATUS_ADDR, 32'h0, 4'hF, q);
            n++;
        end while (q[`ST_BUSY_BIT] !== 1'b0 && n < 400);
        if (n >= 400)
        begin
            n_errors++;
            conclude();
        end
    endtask : run_cmd

    task automatic status_is(input string what, input logic [3:0] exp);
        wb_cycle(1'b0, `WB_STATUS_ADDR, 32'h0, 4'hF, q);
        check(what, {28'h0, exp}, q);
    endtask : status_is

    task automatic read_byte(input logic [7:0] aa, output logic [31:0] rd);
        run_cmd(OP_READ, 2'b00, 8'h00, aa);
        wb_cycle(1'b0, `WB_RDATA_ADDR, 32'h0, 4'hF, rd);
    endtask : read_byte

    task automatic inject(input logic [1:0] c);
        inj_valid <= 1'b1;
        inj_chan  <= c;
        @(posedge clock);
        inj_valid <= 1'b0;
        @(posedge clock);
    endtask : inject

    // ==========================================================================
    // Main sequence.
    // ==========================================================================
    initial
    begin
        {rstn, cyc, stb, we, inj_valid} = '0;
        {adr, sel, dat_w, inj_chan} = '0;
        {n_errors, total_checks} = '0;
        void'($urandom(44444));
        repeat (5) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);

        // Before ready: status idle, unmapped read empty, write command refused.
        status_is("status after reset", 4'h0);
        wb_cycle(1'b0, 4'hC, 32'h0, 4'hF, q);
        check("unmapped read", 32'h0, q);
        run_cmd(OP_WRITE, 2'b00, 8'h3C, 8'h41);
        run_cmd(OP_POLL, 2'b00, 8'h00, 8'h00);
        status_is("status after poll", 4'h2);
        check("checking armed", 32'h1, {31'h0, u_model.armed_q});
        read_byte(8'h41, q);
        check("write refused before ready", 32'h0, q);
        $display("test startup done");

        // Random writes and read-back through the device.
        repeat (4)
        begin
            a = {4'h4, 4'($urandom)};
            d = 8'($urandom);
            run_cmd(OP_WRITE, 2'b00, d, a);
            read_byte(a, q);
            check("read back", {24'h0, d}, q);
        end
        wb_cycle(1'b0, `WB_CMD_ADDR, 32'h0, 4'hF, q);
        check("command readback", {8'h00, a, 16'h0002}, q);
        $display("test write_read done");

        // Illegal condition reported, flag cleared, then channel reset.
        ch = 2'($urandom);
        inject(ch);
        run_cmd(OP_CHSTAT, ch, 8'h00, 8'h00);
        status_is("illegal reported", 4'hE);
        wb_cycle(1'b1, `WB_STATUS_ADDR, 32'h8, 4'h1, q);
        status_is("illegal cleared", 4'h6);
        run_cmd(OP_CRESET, ch, 8'h00, 8'h00);
        status_is("after channel reset", 4'h2);
        run_cmd(OP_CHSTAT, ch, 8'h00, 8'h00);
        status_is("channel status clean", 4'h2);
        $display("test illegal done");

        // Global software reset clears memory and repeats init.
        runs0 = u_model.init_runs;
        run_cmd(OP_WRITE, 2'b00, 8'h77, 8'h43);
        run_cmd(OP_GRESET, 2'b00, 8'h00, 8'h00);
        check("init runs", 32'(runs0 + 1), 32'(u_model.init_runs));
        status_is("ready after global reset", 4'h2);
        read_byte(8'h43, q);
        check("memory zeroed", 32'h0, q);
        $display("test global_reset done");

        // Reset pin pulse behaves as power-up.
        run_cmd(OP_WRITE, 2'b00, 8'h5C, 8'h4F);
        inject(2'($urandom));
        run_cmd(OP_HWRESET, 2'b00, 8'h00, 8'h00);
        check("reset pulse length", 32'(`RST_PULSE_CYC), 32'(u_model.low_len));
        status_is("ready after pin reset", 4'h2);
        read_byte(8'h4F, q);
        check("memory after pin reset", 32'h0, q);
        $display("test pin_reset done");
        conclude();
    end
endmodule : testbench
